// ===== hdl/cad_coproc_access_decode.sv
// Purpose: Decode coprocessor instructions, select target, check access.
// Assumes: One instruction offered per i_instr_valid pulse, flags current.
// Notes:   All results appear one clock after the instruction is offered.
//
// Notes on behaviour
// - System-control coprocessor access in user mode raises undefined.
// - Load/store to system-control coprocessor raises undefined always.
// - Privileged debug/perf unit takes register moves and load/store.
// - Debug/perf coprocessor access in user mode raises undefined.
// - Data-op and dual moves to those two units raise undefined.
// - Direction bit 0 writes coprocessor register, 1 reads it.
// - Coprocessor register number comes from bits 19:16 for register moves, from 15:12 for load/store.
// - Core register number comes from bits 15:12 for register moves; load/store gives zero.
// - Coprocessor number 1111 system-control, 1110 debug/perf, 0000 DSP.
// - Unused register bits read undefined; software writes them zero.
// - System-control writes may land later; completion is observable.
// - Coprocessor zero carries the DSP-specific instructions.
// - Load/store to coprocessors one to thirteen raises undefined.
// - Debug/perf load/store moves one word, opcode and aux fields zero.
// - Load/store direction bit 0 stores, 1 loads.
`timescale 1ns/1ps
module cad_coproc_access_decode (
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_instr_valid,
	input  wire logic [31:0] i_instr,
	input  wire logic [3:0]  i_nzcv,
	input  wire logic        i_privileged,
	input  wire logic        i_sysctl_done,
	output logic             o_xfer_valid,
	output logic             o_xfer_to_coproc,
	output logic [2:0]       o_target,
	output logic [3:0]       o_coproc_reg,
	output logic [3:0]       o_core_reg,
	output logic [2:0]       o_opcode2,
	output logic [3:0]       o_aux_func,
	output logic             o_mem_valid,
	output logic             o_mem_load,
	output logic [3:0]       o_mem_base_reg,
	output logic [7:0]       o_mem_offset,
	output logic             o_dsp_valid,
	output logic [31:0]      o_dsp_instr,
	output logic             o_undef,
	output logic             o_cond_fail,
	output logic             o_sysctl_pending
);
	// ****************************************************************
	// Condition evaluation
	// ****************************************************************
	function automatic logic cond_pass(input logic [3:0] cc,
		input logic [3:0] f);
		logic n, z, c, v;
		n = f[3];
		z = f[2];
		c = f[1];
		v = f[0];
		unique case (cc)
			cad_pkg::CC_EQ: cond_pass = z;
			cad_pkg::CC_NE: cond_pass = !z;
			cad_pkg::CC_CS: cond_pass = c;
			cad_pkg::CC_CC: cond_pass = !c;
			cad_pkg::CC_MI: cond_pass = n;
			cad_pkg::CC_PL: cond_pass = !n;
			cad_pkg::CC_VS: cond_pass = v;
			cad_pkg::CC_VC: cond_pass = !v;
			cad_pkg::CC_HI: cond_pass = c && !z;
			cad_pkg::CC_LS: cond_pass = !c || z;
			cad_pkg::CC_GE: cond_pass = (n == v);
			cad_pkg::CC_LT: cond_pass = (n != v);
			cad_pkg::CC_GT: cond_pass = !z && (n == v);
			cad_pkg::CC_LE: cond_pass = z || (n != v);
			cad_pkg::CC_AL: cond_pass = 1'b1;
			// Never-execute space gives no coprocessor access here
			default:        cond_pass = 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// Instruction class decode
	// ****************************************************************
	wire logic [3:0] f_cond = i_instr[cad_pkg::COND_HI:cad_pkg::COND_LO];
	wire logic [3:0] f_cpn  = i_instr[cad_pkg::CPN_HI:cad_pkg::CPN_LO];
	wire logic       f_dir  = i_instr[cad_pkg::DIR_BIT];

	// Fixed opcode patterns
	wire logic is_cp13 = (i_instr[cad_pkg::CLS_HI:cad_pkg::CLS_LO]
		== cad_pkg::CLS_CP_RT);
	wire logic is_rt   = is_cp13 && i_instr[cad_pkg::RT_BIT];
	wire logic is_dop  = is_cp13 && !i_instr[cad_pkg::RT_BIT];
	wire logic is_dual = (i_instr[cad_pkg::DUAL_HI:cad_pkg::DUAL_LO]
		== cad_pkg::CLS_DUAL);
	wire logic is_ls   = (i_instr[cad_pkg::LS_HI:cad_pkg::LS_LO]
		== cad_pkg::CLS_CP_LS) && !is_dual;
	wire logic is_cp   = is_rt || is_dop || is_dual || is_ls;

	// Condition must pass before any access or exception
	wire logic go      = i_instr_valid && is_cp;
	wire logic passed  = cond_pass(f_cond, i_nzcv);
	wire logic act     = go && passed;

	// Target selection by coprocessor number
	wire logic sel_sys = (f_cpn == cad_pkg::CPN_SYSCTL);
	wire logic sel_dbg = (f_cpn == cad_pkg::CPN_DBGPERF);
	wire logic sel_dsp = (f_cpn == cad_pkg::CPN_DSP);

	// ****************************************************************
	// Access checks
	// ****************************************************************
	wire logic bad_user = (sel_sys || sel_dbg) && !i_privileged;
	wire logic bad_sysls = sel_sys && is_ls;
	wire logic bad_kind = (sel_sys || sel_dbg)
		&& (is_dop || is_dual);
	// Only the debug/perf unit accepts load/store
	wire logic bad_ls   = is_ls && !sel_dbg;
	wire logic bad_num  = !(sel_sys || sel_dbg || sel_dsp);
	wire logic fault    = bad_user || bad_sysls || bad_kind
		|| bad_ls || bad_num;

	wire logic ok       = act && !fault;
	wire logic ok_rt    = ok && is_rt && !sel_dsp;
	wire logic ok_ls    = ok && is_ls;
	wire logic ok_dsp   = ok && sel_dsp && !is_ls;

	// Hardware sets the pending flag; completion clears it, set wins
	wire logic sys_wr   = ok_rt && sel_sys && !f_dir;
	wire logic next_pending = sys_wr || (o_sysctl_pending && !i_sysctl_done);

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_xfer_valid     <= 1'b0;
			o_xfer_to_coproc <= 1'b0;
			o_target         <= 3'h0;
			o_coproc_reg     <= 4'h0;
			o_core_reg       <= 4'h0;
			o_opcode2        <= 3'h0;
			o_aux_func       <= 4'h0;
			o_mem_valid      <= 1'b0;
			o_mem_load       <= 1'b0;
			o_mem_base_reg   <= 4'h0;
			o_mem_offset     <= 8'h00;
			o_dsp_valid      <= 1'b0;
			o_dsp_instr      <= 32'h0000_0000;
			o_undef          <= 1'b0;
			o_cond_fail      <= 1'b0;
			o_sysctl_pending <= 1'b0;
		end else begin
			o_xfer_valid     <= ok_rt;
			o_mem_valid      <= ok_ls;
			o_dsp_valid      <= ok_dsp;
			o_undef          <= act && fault;
			o_cond_fail      <= go && !passed;
			o_sysctl_pending <= next_pending;
			if (ok) begin
				o_target <= {sel_dsp, sel_dbg, sel_sys};
				// Register move: 0 writes coprocessor
				o_xfer_to_coproc <= !f_dir;
				// Load/store: 1 loads from memory
				o_mem_load   <= f_dir;
				o_mem_base_reg <= i_instr[cad_pkg::CRS_HI:cad_pkg::CRS_LO];
				o_mem_offset <= i_instr[cad_pkg::OFS_HI:cad_pkg::OFS_LO];
				o_dsp_instr  <= i_instr;
				if (is_ls) begin
					// Coprocessor register sits in 15:12 here
					o_coproc_reg <= i_instr[cad_pkg::GPR_HI:cad_pkg::GPR_LO];
					o_core_reg   <= 4'h0;
					o_opcode2    <= 3'h0;
					o_aux_func   <= 4'h0;
				end else begin
					o_coproc_reg <= i_instr[cad_pkg::CRS_HI:cad_pkg::CRS_LO];
					o_core_reg   <= i_instr[cad_pkg::GPR_HI:cad_pkg::GPR_LO];
					// Passed unchecked: the core keeps them zero
					o_opcode2    <= i_instr[cad_pkg::OPC2_HI:cad_pkg::OPC2_LO];
					o_aux_func   <= i_instr[cad_pkg::AUX_HI:cad_pkg::AUX_LO];
				end
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	AST_USER_SYS: assert property (go && passed && sel_sys
		&& !i_privileged |=> o_undef && !o_xfer_valid)
		else $error("user access to system control not refused");
	AST_SYS_LS: assert property (go && passed && is_ls && sel_sys
		|=> o_undef && !o_mem_valid)
		else $error("system control load/store not refused");
	AST_DBG_LS: assert property (go && passed && is_ls && sel_dbg
		&& i_privileged |=> o_mem_valid && o_target[cad_pkg::TGT_DBGPERF]
		&& o_opcode2 == 3'h0 && o_aux_func == 4'h0)
		else $error("debug load/store not accepted as one word");
	AST_USER_DBG: assert property (go && passed && sel_dbg
		&& !i_privileged |=> o_undef && !o_mem_valid && !o_xfer_valid)
		else $error("user access to debug unit not refused");
	AST_KIND: assert property (go && passed && (is_dop || is_dual)
		&& (sel_sys || sel_dbg) |=> o_undef)
		else $error("data op or dual move not refused");
	AST_DIR: assert property (ok_rt |=> o_xfer_to_coproc
		== !$past(i_instr[cad_pkg::DIR_BIT]))
		else $error("transfer direction wrong");
	AST_FIELDS: assert property (ok_rt |=> o_coproc_reg
		== $past(i_instr[cad_pkg::CRS_HI:cad_pkg::CRS_LO])
		&& o_core_reg == $past(i_instr[cad_pkg::GPR_HI:cad_pkg::GPR_LO]))
		else $error("register fields wrong");
	AST_PENDING: assert property (sys_wr |=> o_sysctl_pending
		##1 (o_sysctl_pending || $past(i_sysctl_done)))
		else $error("pending flag lost");
	AST_LS_NUM: assert property (go && passed && is_ls
		&& f_cpn != cad_pkg::CPN_DBGPERF |=> o_undef)
		else $error("load/store to other coprocessor not refused");
	AST_LS_DIR: assert property (ok_ls |=> o_mem_load
		== $past(i_instr[cad_pkg::DIR_BIT]))
		else $error("load/store direction wrong");
	AST_COND: assert property (go && !passed |=> o_cond_fail
		&& !o_undef && !o_xfer_valid && !o_mem_valid && !o_dsp_valid)
		else $error("failed condition still acted");
	AST_NUM: assert property (go && passed && is_rt && !sel_sys
		&& !sel_dbg && !sel_dsp |=> o_undef)
		else $error("unknown coprocessor not refused");
	AST_ONEHOT: assert property (o_undef |-> !o_xfer_valid
		&& !o_mem_valid && !o_dsp_valid)
		else $error("exception and access together");
endmodule

// ===== hdl/cad_pkg.sv
// Purpose: Shared constants for the coprocessor access decoder.
// Assumes: 32-bit instruction words as issued by the core pipeline.
// Notes:   Field positions and coprocessor numbers are named here only.
package cad_pkg;
	// ****************************************************************
	// Instruction field positions
	// ****************************************************************
	localparam int COND_HI   = 31;
	localparam int COND_LO   = 28;
	localparam int CLS_HI    = 27;
	localparam int CLS_LO    = 24;
	localparam int LS_HI     = 27;
	localparam int LS_LO     = 25;
	localparam int DUAL_HI   = 27;
	localparam int DUAL_LO   = 21;
	localparam int OPC1_HI   = 23;
	localparam int OPC1_LO   = 21;
	localparam int DIR_BIT   = 20;
	localparam int CRS_HI    = 19;
	localparam int CRS_LO    = 16;
	localparam int GPR_HI    = 15;
	localparam int GPR_LO    = 12;
	localparam int CPN_HI    = 11;
	localparam int CPN_LO    = 8;
	localparam int OPC2_HI   = 7;
	localparam int OPC2_LO   = 5;
	localparam int RT_BIT    = 4;
	localparam int AUX_HI    = 3;
	localparam int AUX_LO    = 0;
	localparam int OFS_HI    = 7;
	localparam int OFS_LO    = 0;

	// ****************************************************************
	// Opcode patterns and coprocessor numbers
	// ****************************************************************
	localparam logic [3:0] CLS_CP_RT   = 4'hE;
	localparam logic [2:0] CLS_CP_LS   = 3'h6;
	localparam logic [6:0] CLS_DUAL    = 7'h62;
	localparam logic [3:0] CPN_SYSCTL  = 4'hF;
	localparam logic [3:0] CPN_DBGPERF = 4'hE;
	localparam logic [3:0] CPN_DSP     = 4'h0;

	// Target select one-hot bit positions
	localparam int TGT_SYSCTL  = 0;
	localparam int TGT_DBGPERF = 1;
	localparam int TGT_DSP     = 2;

	// Condition codes
	localparam logic [3:0] CC_EQ = 4'h0;
	localparam logic [3:0] CC_NE = 4'h1;
	localparam logic [3:0] CC_CS = 4'h2;
	localparam logic [3:0] CC_CC = 4'h3;
	localparam logic [3:0] CC_MI = 4'h4;
	localparam logic [3:0] CC_PL = 4'h5;
	localparam logic [3:0] CC_VS = 4'h6;
	localparam logic [3:0] CC_VC = 4'h7;
	localparam logic [3:0] CC_HI = 4'h8;
	localparam logic [3:0] CC_LS = 4'h9;
	localparam logic [3:0] CC_GE = 4'hA;
	localparam logic [3:0] CC_LT = 4'hB;
	localparam logic [3:0] CC_GT = 4'hC;
	localparam logic [3:0] CC_LE = 4'hD;
	localparam logic [3:0] CC_AL = 4'hE;
endpackage

// ===== test/cad_core_model.sv
// Purpose: Core-side model that reports delayed system-control completion.
// Assumes: Completion is signalled DLY cycles after the pending flag rises.
// Notes:   A slow setting exercises the window where the flag must hold.
`timescale 1ns/1ps
module cad_core_model #(
	parameter int DLY = 6
) (
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	input  wire logic i_pending,
	output logic      o_done
);
	logic [7:0] wait_cnt;

	always_ff @(posedge i_mclk) begin
		// Restart on each report so a later write gets its own full delay
		if (i_sys_rst || !i_pending || o_done) begin
			wait_cnt <= 8'h00;
		end else begin
			wait_cnt <= wait_cnt + 8'h01;
		end
	end

	// Done is a level only at the end of the delay, low otherwise
	assign o_done = i_pending && (wait_cnt == 8'(DLY));
endmodule

// ===== test/testbench.sv
// Purpose: Self-checking bench for the coprocessor access decoder.
// Assumes: One instruction per call; results checked one edge later.
// Notes:   Reserved opcode field is zero in all words.
`timescale 1ns/1ps
module testbench;
	localparam int         DLY = 6;
	localparam logic [4:0] XF  = 5'h10;
	localparam logic [4:0] MV  = 5'h08;
	localparam logic [4:0] DS  = 5'h04;
	localparam logic [4:0] UD  = 5'h02;
	localparam logic [4:0] CF  = 5'h01;
	// Flag sets N,Z,C,V per nibble and the condition codes each passes
	localparam logic [15:0] FL = 16'h82F0;
	localparam logic [63:0] PM = 64'h6A9A_55A6_6655_56AA;
	logic        i_mclk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_instr_valid = 1'b0;
	logic [31:0] i_instr = 32'h0;
	logic [3:0]  i_nzcv = 4'h0;
	logic        i_privileged = 1'b0;
	logic        i_sysctl_done;
	logic        o_xfer_valid, o_xfer_to_coproc, o_mem_valid, o_mem_load;
	logic        o_dsp_valid, o_undef, o_cond_fail, o_sysctl_pending;
	logic [2:0]  o_target, o_opcode2;
	logic [3:0]  o_coproc_reg, o_core_reg, o_aux_func, o_mem_base_reg;
	logic [7:0]  o_mem_offset;
	logic [31:0] o_dsp_instr;
	int          err_count = 0;
	int          total_checks = 0;
	int          n;
	int          k;
	wire  [4:0]  res = {o_xfer_valid, o_mem_valid, o_dsp_valid, o_undef,
		o_cond_fail};

	always #20 i_mclk = ~i_mclk;

	cad_coproc_access_decode cad_coproc_access_decode_inst (
		.i_mclk           (i_mclk),
		.i_sys_rst        (i_sys_rst),
		.i_instr_valid    (i_instr_valid),
		.i_instr          (i_instr),
		.i_nzcv           (i_nzcv),
		.i_privileged     (i_privileged),
		.i_sysctl_done    (i_sysctl_done),
		.o_xfer_valid     (o_xfer_valid),
		.o_xfer_to_coproc (o_xfer_to_coproc),
		.o_target         (o_target),
		.o_coproc_reg     (o_coproc_reg),
		.o_core_reg       (o_core_reg),
		.o_opcode2        (o_opcode2),
		.o_aux_func       (o_aux_func),
		.o_mem_valid      (o_mem_valid),
		.o_mem_load       (o_mem_load),
		.o_mem_base_reg   (o_mem_base_reg),
		.o_mem_offset     (o_mem_offset),
		.o_dsp_valid      (o_dsp_valid),
		.o_dsp_instr      (o_dsp_instr),
		.o_undef          (o_undef),
		.o_cond_fail      (o_cond_fail),
		.o_sysctl_pending (o_sysctl_pending)
	);
	cad_core_model #(.DLY(DLY)) cad_core_model_inst (.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst), .i_pending(o_sysctl_pending),
		.o_done(i_sysctl_done));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Offer one word, then compare the one-cycle result pulses
	task automatic run(input logic [31:0] w, input logic p,
		input logic [3:0] f, input logic [4:0] e);
		@(posedge i_mclk);
		i_instr_valid <= 1'b1;
		i_instr <= w;
		i_privileged <= p;
		i_nzcv <= f;
		@(posedge i_mclk);
		i_instr_valid <= 1'b0;
		#1;
		chk({27'h0, res}, {27'h0, e});
	endtask

	task automatic finish_test();
		if (err_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge i_mclk);
		#1;
		chk({27'h0, res}, 32'h0);
		@(posedge i_mclk);
		i_sys_rst <= 1'b0;
		// Reserved opcode field always zero
		// Function bits nonzero only where a command defines them
		run(32'hEE011F10, 1'b1, 4'h0, XF);
		chk({13'h0, o_xfer_to_coproc, o_target, o_coproc_reg, o_core_reg,
			o_opcode2, o_aux_func}, {13'h0, 1'b1, 3'h1, 4'h1, 4'h1, 3'h0,
			4'h0});
		run(32'hEE011F10, 1'b0, 4'h0, UD);
		run(32'hEE1A5E33, 1'b1, 4'h0, XF);
		chk({13'h0, o_xfer_to_coproc, o_target, o_coproc_reg, o_core_reg,
			o_opcode2, o_aux_func}, {13'h0, 1'b0, 3'h2, 4'hA, 4'h5, 3'h1,
			4'h3});
		run(32'hEE1A5E33, 1'b0, 4'h0, UD);
		run(32'hED911E02, 1'b1, 4'h0, MV);
		chk({11'h0, o_mem_load, o_mem_base_reg, o_coproc_reg, o_core_reg,
			o_mem_offset}, {11'h0, 1'b1, 4'h1, 4'h1, 4'h0, 8'h02});
		run(32'hED8A3E7F, 1'b1, 4'h0, MV);
		chk({4'h0, o_mem_load, o_mem_base_reg, o_coproc_reg, o_core_reg,
			o_opcode2, o_aux_func, o_mem_offset}, {8'h0, 1'b0, 4'hA, 4'h3,
			4'h0, 3'h0, 4'h0, 8'h7F});
		run(32'hED911E02, 1'b0, 4'h0, UD);
		for (n = 0; n < 16; n++) begin
			if (n != 14) begin
				run(32'hED911002 | (32'(n) << 8), 1'b1, 4'h0, UD);
			end
		end
		run(32'hEE011F00, 1'b1, 4'h0, UD);
		run(32'hEE011E00, 1'b1, 4'h0, UD);
		run(32'hEC411F00, 1'b1, 4'h0, UD);
		run(32'hEC511E00, 1'b1, 4'h0, UD);
		run(32'hEE011010, 1'b0, 4'h0, DS);
		chk({29'h0, o_target}, 32'h4);
		run(32'hEE021000, 1'b1, 4'h0, DS);
		chk(o_dsp_instr, 32'hEE021000);
		run(32'hEE011710, 1'b1, 4'h0, UD);
		run(32'h0E011F10, 1'b1, 4'h0, CF);
		run(32'h0E011F10, 1'b1, 4'h4, XF);
		run(32'h0E011F10, 1'b0, 4'h0, CF);
		run(32'hE1A00000, 1'b1, 4'h0, 5'h00);
		// Every condition code against four flag settings
		for (k = 0; k < 4; k++) begin
			for (n = 0; n < 16; n++) begin
				run({4'(n), 28'hE01_1010}, 1'b0, FL[k * 4 +: 4],
					PM[k * 16 + n] ? DS : CF);
			end
		end
		repeat (20) @(posedge i_mclk);
		run(32'hEE111F10, 1'b1, 4'h0, XF);
		chk({31'h0, o_sysctl_pending}, 32'h0);
		run(32'hEE011F10, 1'b1, 4'h0, XF);
		chk({31'h0, o_sysctl_pending}, 32'h1);
		n = 0;
		while (o_sysctl_pending === 1'b1 && n < 40) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		chk(32'(n), 32'(DLY + 1));
		// Second write lands in the cycle the core reports the first
		run(32'hEE011F10, 1'b1, 4'h0, XF);
		repeat (5) @(posedge i_mclk);
		run(32'hEE011F10, 1'b1, 4'h0, XF);
		chk({31'h0, o_sysctl_pending}, 32'h1);
		// Mid-run reset clears a pending flag and every result
		@(posedge i_mclk);
		i_sys_rst <= 1'b1;
		@(posedge i_mclk);
		#1;
		chk({23'h0, o_target, o_sysctl_pending, res}, 32'h0);
		@(posedge i_mclk);
		i_sys_rst <= 1'b0;
		run(32'hEE1A5E33, 1'b1, 4'h0, XF);
		chk({29'h0, o_target}, 32'h2);
		finish_test();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_mclk);
		err_count++;
		finish_test();
	end
endmodule
